// ==== rtl/odm_device.sv ====
// display-memory access logic of the on-screen display device
module odm_device
   import odm_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   odm_link_if.device       link,
   input  wire logic        i_vid_req,
   input  wire logic [8:0]  i_vid_addr,
   output logic             o_vid_valid,
   output logic [7:0]       o_vid_char,
   output logic [7:0]       o_vid_attr,
   output logic [7:0]       o_video_mode
);
   localparam int DEPTH = 2 ** ODM_ADDR_W;

   // ----------------------------------------------------------------
   // link side, clocked by the serial clock
   // ----------------------------------------------------------------
   logic        frame_rst_b;
   logic [4:0]  bit_cnt_reg;
   logic [14:0] rx_reg;
   logic [15:0] cmd_word_reg;
   logic        req_tgl_reg;
   logic [15:0] tx_reg;
   logic        tx_en_reg;
   logic [15:0] rd_snap_reg;
   wire         frame_done;
   wire         load_point;
   wire         rd_cmd;
   wire  [15:0] tx_load;

   // the frame's own select ends it, the link clock may stop afterwards
   assign frame_rst_b = i_rst_b & ~link.cs_b;
   assign frame_done  = (bit_cnt_reg == ODM_FRAME_BITS - 5'd1);
   assign load_point  = (bit_cnt_reg == ODM_LOAD_BIT);
   assign rd_cmd      = rx_reg[7];
   // snapshot only changes after a handled frame, so it is quiet here
   assign tx_load     = (rx_reg[6:0] == ODM_REG_READ_DATA) ? rd_snap_reg
                                                          : 16'h0000;

   always_ff @(posedge link.sclk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
      begin
         bit_cnt_reg <= 5'd0;
         rx_reg      <= 15'h0000;
      end
      else
      begin
         if (bit_cnt_reg != 5'd31)
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
         rx_reg <= {rx_reg[13:0], link.sdin};
      end
   end

   // word is held until the next frame's sixteenth edge
   always_ff @(posedge link.sclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cmd_word_reg <= 16'h0000;
         req_tgl_reg  <= 1'b0;
      end
      else if (frame_done)
      begin
         cmd_word_reg <= {rx_reg, link.sdin};
         req_tgl_reg  <= ~req_tgl_reg;
      end
   end

   // read data launches on falling edges, after the address byte
   always_ff @(negedge link.sclk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
      begin
         tx_reg    <= 16'h0000;
         tx_en_reg <= 1'b0;
      end
      else if (load_point && rd_cmd)
      begin
         tx_reg    <= tx_load;
         tx_en_reg <= 1'b1;
      end
      else
         tx_reg <= {tx_reg[14:0], 1'b0};
   end

   assign link.sdout    = tx_reg[15];
   assign link.sdout_oe = tx_en_reg & ~link.cs_b;

   // ----------------------------------------------------------------
   // crossing into the device clock
   // ----------------------------------------------------------------
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   wire  cmd_pulse;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= req_tgl_reg;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign cmd_pulse = s2_reg ^ s3_reg;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic [7:0] mode_reg;
   logic [7:0] addr_high_reg;
   logic [7:0] addr_low_reg;
   logic [7:0] vm_reg;
   logic [7:0] char_mem [DEPTH];
   logic [7:0] attr_mem [DEPTH];

   wire        cmd_wr;
   wire [6:0]  cmd_reg;
   wire [7:0]  cmd_data;
   wire        auto_on;
   wire        byte_mode;
   wire        attr_sel;
   wire [8:0]  addr;
   wire        data_wr;
   wire        term;
   wire        store;
   wire        store_char;
   wire        store_attr;
   wire [7:0]  attr_word;
   wire        advance;
   wire [8:0]  addr_inc;

   assign cmd_wr    = cmd_pulse & ~cmd_word_reg[ODM_RW_BIT];
   assign cmd_reg   = cmd_word_reg[14:8];
   assign cmd_data  = cmd_word_reg[7:0];
   assign auto_on   = mode_reg[ODM_AUTO_BIT];
   assign byte_mode = mode_reg[ODM_BYTE_BIT];
   assign attr_sel  = addr_high_reg[ODM_SEL_BIT];
   assign addr      = {addr_high_reg[ODM_MSB_BIT], addr_low_reg};
   assign data_wr   = cmd_wr & (cmd_reg == ODM_REG_WRITE_DATA);
   assign term      = data_wr & auto_on & (cmd_data == ODM_TERM_CODE);
   assign store     = data_wr & ~term;
   assign store_char = store & ~(byte_mode & attr_sel);
   assign store_attr = store & byte_mode & attr_sel;
   assign attr_word = {mode_reg[ODM_ATTR_LSB +: 3], 5'b0_0000};
   assign advance   = store & auto_on & (addr != ODM_LAST_ADDR);
   assign addr_inc  = addr + 9'd1;

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         mode_reg      <= ODM_RESET_BYTE;
         addr_high_reg <= ODM_RESET_BYTE;
         addr_low_reg  <= ODM_RESET_BYTE;
         vm_reg        <= ODM_RESET_BYTE;
      end
      else
      begin
         if (cmd_wr && cmd_reg == ODM_REG_MODE)
            mode_reg <= cmd_data;
         else if (term)
            mode_reg[ODM_AUTO_BIT] <= 1'b0;
         if (cmd_wr && cmd_reg == ODM_REG_VIDEO_MODE)
            vm_reg <= cmd_data;
         if (advance)
         begin
            addr_high_reg[ODM_MSB_BIT] <= addr_inc[8];
            addr_low_reg               <= addr_inc[7:0];
         end
         else
         begin
            if (cmd_wr && cmd_reg == ODM_REG_ADDR_HIGH)
               addr_high_reg <= cmd_data;
            if (cmd_wr && cmd_reg == ODM_REG_ADDR_LOW)
               addr_low_reg <= cmd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // display memory, host writes and video readout
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (store_char)
         char_mem[addr] <= cmd_data;
      if (store_attr)
         attr_mem[addr] <= cmd_data;
      else if (store_char && !byte_mode)
         attr_mem[addr] <= attr_word;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rd_snap_reg  <= 16'h0000;
         o_vid_valid  <= 1'b0;
         o_vid_char   <= ODM_RESET_BYTE;
         o_vid_attr   <= ODM_RESET_BYTE;
         o_video_mode <= ODM_RESET_BYTE;
      end
      else
      begin
         if (byte_mode)
            rd_snap_reg <= {attr_sel ? attr_mem[addr] : char_mem[addr], 8'h00};
         else
            rd_snap_reg <= {char_mem[addr], odm_attr_read(attr_mem[addr])};
         o_vid_valid <= i_vid_req & ~cmd_pulse;
         if (i_vid_req && !cmd_pulse)
         begin
            o_vid_char <= char_mem[i_vid_addr];
            o_vid_attr <= attr_mem[i_vid_addr];
         end
         o_video_mode <= vm_reg;
      end
   end

endmodule // odm_device

// ==== rtl/odm_host.sv ====
// host controller end of the display-memory serial link
module odm_host
   import odm_pkg::*;
#(
   parameter int HALF = ODM_HOST_HALF,
   parameter int GAP  = ODM_HOST_GAP
)
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   odm_link_if.host         link,
   input  wire logic        i_req,
   input  wire logic        i_rd,
   input  wire logic [6:0]  i_reg_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_vblank,
   output logic             o_ready,
   output logic             o_done,
   output logic             o_reject,
   output logic [15:0]      o_rdata
);
   typedef enum logic [1:0] {IDLE, WAIT_VB, SHIFT, PAUSE} odm_state_type;

   odm_state_type state_reg;
   logic [7:0]  div_reg;
   logic [4:0]  bit_reg;
   logic [4:0]  nbits_reg;
   logic [23:0] tx_reg;
   logic [15:0] rx_reg;
   logic        sclk_reg;
   logic        cs_b_reg;
   logic        auto_reg;
   logic        byte_reg;
   logic        do1_reg;
   logic        do2_reg;
   logic        vb1_reg;
   logic        vb2_reg;

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   wire take      = i_req & (state_reg == IDLE);
   wire refuse    = take & i_rd & auto_reg;
   wire accept    = take & ~refuse;
   wire mode_wr   = accept & ~i_rd & (i_reg_addr == ODM_REG_MODE);
   wire data_wr   = accept & ~i_rd & (i_reg_addr == ODM_REG_WRITE_DATA);
   wire word_rd   = i_rd & ~byte_reg & (i_reg_addr == ODM_REG_READ_DATA);
   wire tick      = (div_reg == 8'(HALF - 1));
   wire last_bit  = (bit_reg == nbits_reg - 5'd1);

   assign o_ready   = (state_reg == IDLE);
   assign link.sclk = sclk_reg;
   assign link.cs_b = cs_b_reg;
   assign link.sdin = tx_reg[23];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         do1_reg <= 1'b1;
         do2_reg <= 1'b1;
         vb1_reg <= 1'b0;
         vb2_reg <= 1'b0;
      end
      else
      begin
         do1_reg <= link.sdout_line;
         do2_reg <= do1_reg;
         vb1_reg <= i_vblank;
         vb2_reg <= vb1_reg;
      end
   end

   // ----------------------------------------------------------------
   // frame sequencer and clock divider
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_reg <= IDLE;
         div_reg   <= 8'd0;
         bit_reg   <= 5'd0;
         nbits_reg <= ODM_FRAME_BITS;
         tx_reg    <= 24'h00_0000;
         rx_reg    <= 16'h0000;
         sclk_reg  <= 1'b0;
         cs_b_reg  <= 1'b1;
         auto_reg  <= 1'b0;
         byte_reg  <= 1'b0;
         o_done    <= 1'b0;
         o_reject  <= 1'b0;
         o_rdata   <= 16'h0000;
      end
      else
      begin
         o_done   <= 1'b0;
         o_reject <= refuse;
         case (state_reg)
            IDLE:
            begin
               div_reg <= 8'd0;
               bit_reg <= 5'd0;
               if (accept)
               begin
                  tx_reg    <= {i_rd, i_reg_addr, i_wdata, 8'h00};
                  nbits_reg <= word_rd ? ODM_WORD_BITS : ODM_FRAME_BITS;
                  if (mode_wr)
                  begin
                     auto_reg <= i_wdata[ODM_AUTO_BIT];
                     byte_reg <= i_wdata[ODM_BYTE_BIT];
                  end
                  if (data_wr && auto_reg && i_wdata == ODM_TERM_CODE)
                     auto_reg <= 1'b0;
                  state_reg <= data_wr ? WAIT_VB : SHIFT;
               end
            end
            WAIT_VB:
               if (vb2_reg)
                  state_reg <= SHIFT;
            SHIFT:
            begin
               cs_b_reg <= 1'b0;
               div_reg  <= tick ? 8'd0 : div_reg + 8'd1;
               if (tick)
               begin
                  sclk_reg <= ~sclk_reg;
                  if (!sclk_reg)
                     rx_reg <= {rx_reg[14:0], do2_reg};
                  else
                  begin
                     tx_reg  <= {tx_reg[22:0], 1'b0};
                     bit_reg <= bit_reg + 5'd1;
                     if (last_bit)
                     begin
                        state_reg <= PAUSE;
                        div_reg   <= 8'd0;
                        o_done    <= 1'b1;
                        o_rdata   <= (nbits_reg == ODM_WORD_BITS) ? rx_reg
                                                                  : {8'h00, rx_reg[7:0]};
                     end
                  end
               end
            end
            PAUSE:
            begin
               cs_b_reg <= 1'b1;
               div_reg  <= div_reg + 8'd1;
               // gap lets the device take the word before the next frame
               if (div_reg == 8'(GAP - 1))
                  state_reg <= IDLE;
            end
            default:
               state_reg <= IDLE;
         endcase
      end
   end

endmodule // odm_host

// ==== rtl/odm_link_if.sv ====
// serial link between host controller and display-memory device
interface odm_link_if;
   logic cs_b;
   logic sclk;
   logic sdin;
   logic sdout;
   logic sdout_oe;
   logic sdout_line;

   // pulled high while the device is not driving
   assign sdout_line = sdout_oe ? sdout : 1'b1;

   modport device (input cs_b, input sclk, input sdin, input sdout_line,
                   output sdout, output sdout_oe);
   modport host   (output cs_b, output sclk, output sdin, input sdout_line);
endinterface : odm_link_if

// ==== rtl/odm_pkg.sv ====
// constants shared by both ends of the display-memory access link
// Summary of operation
// - mode bit 0 turns on auto-increment writes
// - auto-increment advances address after each write, holding at 1FFh
// - code FFh ends auto-increment operation
// - host must not read while auto-increment on
// - byte mode: select bit picks char/attribute
// - address is high bit 0 plus low byte
// - mode bit 6 selects byte or word mode
// - word mode stores attribute from mode bits 5:3
// - byte mode read returns selected byte
// - word mode read returns char then attribute
// - video readout dropped on host access collision
// - host writes to the write-data register during vertical blanking
package odm_pkg;
   // ----------------------------------------------------------------
   // register map, 7-bit register number after the read/write bit
   // ----------------------------------------------------------------
   localparam logic [6:0] ODM_REG_VIDEO_MODE = 7'h00;
   localparam logic [6:0] ODM_REG_MODE       = 7'h04;
   localparam logic [6:0] ODM_REG_ADDR_HIGH  = 7'h05;
   localparam logic [6:0] ODM_REG_ADDR_LOW   = 7'h06;
   localparam logic [6:0] ODM_REG_WRITE_DATA = 7'h07;
   localparam logic [6:0] ODM_REG_READ_DATA  = 7'h30;
   // ----------------------------------------------------------------
   // field positions and values
   // ----------------------------------------------------------------
   localparam int         ODM_RW_BIT       = 15;
   localparam int         ODM_AUTO_BIT     = 0;
   localparam int         ODM_BYTE_BIT     = 6;
   localparam int         ODM_ATTR_LSB     = 3;
   localparam int         ODM_SEL_BIT      = 1;
   localparam int         ODM_MSB_BIT      = 0;
   localparam logic [7:0] ODM_TERM_CODE    = 8'hFF;
   localparam logic [7:0] ODM_RESET_BYTE   = 8'h00;
   localparam int         ODM_ADDR_W       = 9;
   localparam logic [8:0] ODM_LAST_ADDR    = 9'h1FF;
   // ----------------------------------------------------------------
   // frame lengths and host timing counts
   // ----------------------------------------------------------------
   localparam logic [4:0] ODM_FRAME_BITS   = 5'd16;
   localparam logic [4:0] ODM_WORD_BITS    = 5'd24;
   localparam logic [4:0] ODM_LOAD_BIT     = 5'd8;
   localparam int         ODM_HOST_HALF    = 4;
   localparam int         ODM_HOST_GAP     = 16;

   // stored attribute keeps flags in bits 7:5; read returns them in 2:0
   function automatic logic [7:0] odm_attr_read(input logic [7:0] a);
      odm_attr_read = {5'b0_0000, a[7:5]};
   endfunction
endpackage : odm_pkg

// ==== sim/odm_asserts.sv ====
// concurrent checks on the display-memory serial link wire
module odm_asserts
   import odm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic cs_b,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic sdout,
   input wire logic sdout_oe,
   input wire logic sdout_line
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // frame decode on the host clock
   // ----------------------------------------------------------------
   logic        sclk_reg;
   logic        cs_reg;
   logic        step_reg;
   logic [4:0]  cnt_reg;
   logic [23:0] sh_reg;
   logic [7:0]  hdr_reg;
   logic        auto_reg;
   logic        byte_reg;
   wire         rise    = sclk & ~sclk_reg & ~cs_b;
   wire         fr_end  = cs_b & ~cs_reg & (cnt_reg == 5'h10) & ~hdr_reg[7];
   wire         mode_wr = fr_end & (hdr_reg[6:0] == ODM_REG_MODE);
   wire         term_wr = fr_end & (hdr_reg[6:0] == ODM_REG_WRITE_DATA)
                          & (sh_reg[7:0] == ODM_TERM_CODE);
   // only a word-mode read of the data-out register carries two data bytes
   wire         long_fr = (hdr_reg == {1'b1, ODM_REG_READ_DATA}) & ~byte_reg;
   wire [4:0]   want_len = long_fr ? 5'h18 : 5'h10;

   always_ff @(posedge i_clk or negedge i_rst_b)
      if (!i_rst_b)
      begin
         // select history starts at its idle high level, so no false frame end
         {sclk_reg, cs_reg, step_reg, auto_reg, byte_reg} <= 5'h08;
         cnt_reg <= 5'h00;
         sh_reg  <= 24'h00_0000;
         hdr_reg <= 8'h00;
      end
      else
      begin
         sclk_reg <= sclk;
         cs_reg   <= cs_b;
         step_reg <= rise;
         cnt_reg  <= cs_b ? 5'h00 : cnt_reg + {4'h0, rise};
         sh_reg   <= rise ? {sh_reg[22:0], sdin} : sh_reg;
         hdr_reg  <= (step_reg && cnt_reg == 5'h08) ? sh_reg[7:0] : hdr_reg;
         auto_reg <= mode_wr ? sh_reg[ODM_AUTO_BIT] : (term_wr ? 1'b0 : auto_reg);
         byte_reg <= mode_wr ? sh_reg[ODM_BYTE_BIT] : byte_reg;
      end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_hdr_done;
      step_reg && cnt_reg == 5'h08;
   endsequence
   sequence s_frame_end;
      $rose(cs_b);
   endsequence

   chk_sclk_idle_low: assert property (cs_b && $past(cs_b) |-> !sclk)
      else $error("link clock moves outside a frame");
   chk_sclk_half_span: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
      else $error("link clock high phase has wrong length");
   chk_sdin_hold: assert property (sclk && $past(sclk) |-> $stable(sdin))
      else $error("host data changed while link clock high");
   chk_oe_released: assert property (cs_b && $past(cs_b) |-> !sdout_oe)
      else $error("device drives data line outside a frame");
   chk_oe_on_read: assert property ($rose(sdout_oe) |-> cnt_reg == 5'h08 && hdr_reg[7])
      else $error("device drove data line outside a read phase");
   chk_sdout_hold: assert property (sdout_oe && sclk && $past(sclk) |-> $stable(sdout_line))
      else $error("device data changed while link clock high");
   chk_frame_len: assert property (s_frame_end |-> cnt_reg == want_len)
      else $error("frame length does not fit its register and mode");
   chk_no_auto_read: assert property (s_hdr_done |-> !(sh_reg[7] && auto_reg))
      else $error("read frame sent while auto-increment active");
   chk_frame_gap: assert property (s_frame_end |-> cs_b[*8])
      else $error("select released too briefly between frames");
endmodule // odm_asserts

// ==== sim/osd_display_memory_access_tb.sv ====
// self-checking bench joining host and device ends over the serial link
module osd_display_memory_access_tb
   import odm_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk;
   logic        dclk;
   logic        rst_b;
   logic        req;
   logic        rd;
   logic [6:0]  ra;
   logic [7:0]  wd;
   logic        vblank;
   logic        ready;
   logic        done;
   logic        rej;
   logic [15:0] rdata;
   logic        vreq;
   logic        vq;
   logic [8:0]  vaddr;
   logic        vvalid;
   logic [7:0]  vchar;
   logic [7:0]  vattr;
   logic [7:0]  vmode;
   logic [7:0]  drops;
   logic        dn;
   logic        rj;
   int          fails;
   int          n_checks;

   odm_link_if lnk ();
   odm_host i_odm_host (.i_clk(clk), .i_rst_b(rst_b), .link(lnk), .i_req(req), .i_rd(rd),
      .i_reg_addr(ra), .i_wdata(wd), .i_vblank(vblank), .o_ready(ready), .o_done(done),
      .o_reject(rej), .o_rdata(rdata));
   odm_device i_odm_device (.i_clk(dclk), .i_rst_b(rst_b), .link(lnk), .i_vid_req(vreq),
      .i_vid_addr(vaddr), .o_vid_valid(vvalid), .o_vid_char(vchar), .o_vid_attr(vattr),
      .o_video_mode(vmode));
   odm_asserts i_odm_asserts (.i_clk(clk), .i_rst_b(rst_b), .cs_b(lnk.cs_b),
      .sclk(lnk.sclk), .sdin(lnk.sdin), .sdout(lnk.sdout), .sdout_oe(lnk.sdout_oe),
      .sdout_line(lnk.sdout_line));

   always #25 clk = ~clk;
   always #15 dclk = ~dclk;

   // each host frame may cost one video request; count the ones dropped
   // looked at on the falling edge, where the answer to the last rise stands
   always @(negedge dclk)
   begin
      if (vq && vvalid !== 1'b1)
         drops = drops + 8'h01;
      vq = vreq;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic op(input logic r, input logic [6:0] a, input logic [7:0] w);
      int n;
      for (n = 0; n < 100 && ready !== 1'b1; n++)
         @(negedge clk);
      // a host stuck busy is a failure, not a silent skip
      if (ready !== 1'b1)
      begin
         fails++;
         $display("Error at %0t: host never became ready", $time);
      end
      @(posedge clk);
      req <= 1'b1;
      rd  <= r;
      ra  <= a;
      wd  <= w;
      @(posedge clk);
      req <= 1'b0;
      dn = 1'b0;
      rj = 1'b0;
      // done and refusal stand one cycle, so look at every falling edge
      for (n = 0; n < 3000 && !dn && !rj; n++)
      begin
         @(negedge clk);
         dn = (done === 1'b1);
         rj = (rej === 1'b1);
      end
      if (!dn && !rj)
      begin
         fails++;
         $display("Error at %0t: host request never answered", $time);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] w);
      op(1'b0, a, w);
   endtask

   task automatic vid(input logic [8:0] a, input logic [7:0] c, input logic [7:0] t);
      repeat (6) @(posedge dclk);
      vreq  <= 1'b1;
      vaddr <= a;
      @(posedge dclk);
      vreq <= 1'b0;
      @(negedge dclk);
      chk({7'h00, vvalid, vchar, vattr}, {7'h00, 1'b1, c, t});
   endtask

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_word_auto;
      wr(ODM_REG_ADDR_HIGH, 8'h01);
      wr(ODM_REG_ADDR_LOW, 8'hFE);
      wr(ODM_REG_MODE, 8'h29);
      wr(ODM_REG_WRITE_DATA, 8'h41);
      wr(ODM_REG_WRITE_DATA, 8'h42);
      // the last address holds: the third code overwrites the second
      wr(ODM_REG_WRITE_DATA, 8'h43);
      wr(ODM_REG_WRITE_DATA, ODM_TERM_CODE);
      vid(9'h1FE, 8'h41, 8'hA0);
      vid(9'h1FF, 8'h43, 8'hA0);
      wr(ODM_REG_ADDR_LOW, 8'hFE);
      op(1'b1, ODM_REG_READ_DATA, 8'h00);
      chk({dn, rj, 6'h00, rdata}, 24'h80_4105);
      $display("word auto test finished");
   endtask

   task automatic t_reject;
      wr(ODM_REG_MODE, 8'h01);
      op(1'b1, ODM_REG_READ_DATA, 8'h00);
      chk({22'h0, dn, rj}, 24'h00_0001);
      wr(ODM_REG_WRITE_DATA, ODM_TERM_CODE);
      op(1'b1, ODM_REG_READ_DATA, 8'h00);
      chk({dn, rj, 6'h00, rdata}, 24'h80_4105);
      $display("reject test finished");
   endtask

   task automatic t_byte;
      wr(ODM_REG_MODE, 8'h40);
      wr(ODM_REG_ADDR_HIGH, 8'h02);
      wr(ODM_REG_ADDR_LOW, 8'h10);
      wr(ODM_REG_WRITE_DATA, 8'h5A);
      wr(ODM_REG_ADDR_HIGH, 8'h00);
      wr(ODM_REG_WRITE_DATA, 8'h33);
      vid(9'h010, 8'h33, 8'h5A);
      op(1'b1, ODM_REG_READ_DATA, 8'h00);
      chk({8'h00, rdata}, 24'h00_0033);
      wr(ODM_REG_ADDR_HIGH, 8'h02);
      op(1'b1, ODM_REG_READ_DATA, 8'h00);
      chk({8'h00, rdata}, 24'h00_005A);
      wr(ODM_REG_ADDR_LOW, 8'h0F);
      wr(ODM_REG_MODE, 8'h41);
      wr(ODM_REG_WRITE_DATA, 8'h11);
      wr(ODM_REG_WRITE_DATA, 8'h22);
      wr(ODM_REG_WRITE_DATA, ODM_TERM_CODE);
      vid(9'h010, 8'h33, 8'h22);
      $display("byte mode test finished");
   endtask

   task automatic t_vblank;
      @(posedge clk);
      vblank <= 1'b0;
      fork
         wr(ODM_REG_WRITE_DATA, 8'h66);
         begin
            repeat (200) @(negedge clk);
            chk({23'h0, lnk.cs_b}, 24'h00_0001);
            @(posedge clk);
            vblank <= 1'b1;
         end
      join
      chk({22'h0, dn, rj}, 24'h00_0002);
      $display("vblank test finished");
   endtask

   task automatic t_collide;
      drops = 8'h00;
      @(posedge dclk);
      vreq  <= 1'b1;
      vaddr <= 9'h010;
      wr(ODM_REG_VIDEO_MODE, 8'h0C);
      @(posedge dclk);
      vreq <= 1'b0;
      repeat (4) @(posedge dclk);
      chk({16'h0000, drops}, 24'h00_0001);
      chk({16'h0000, vmode}, 24'h00_000C);
      $display("collision test finished");
   endtask

   initial
   begin
      {clk, dclk, rst_b, req, rd, vreq, vq, dn, rj} = 9'h000;
      {ra, wd, vaddr, drops} = 32'h0000_0000;
      vblank = 1'b1;
      fails = 0;
      n_checks = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_word_auto;
      t_reject;
      t_byte;
      t_vblank;
      t_collide;
      report_and_stop;
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      fails++;
      report_and_stop;
   end
endmodule // osd_display_memory_access_tb
